// ===== rtcs_pkg.sv
// rtcs_pkg: shared constants for the two-wire rtc slave front end and its bus master.
// assumes the slave runs on a 6 ns link clock and the master on a 4 ns system clock.
package rtcs_pkg;

    // control codes, upper seven bits of the control byte
    localparam logic [6:0] EE_CODE      = 7'h57;
    localparam logic [6:0] RAM_CODE     = 7'h6F;
    // highest implemented sram/clock-register address
    localparam logic [7:0] RAM_LAST     = 8'h5F;
    // eeprom word address is seven bits wide
    localparam logic [7:0] EE_ADDR_MASK = 8'h7F;
    localparam logic [3:0] BIT_ACK      = 4'h8;

    // eeprom write cycle, longest time, rounded down
    localparam int LINK_PERIOD_NS = 6;
    localparam int TWC_MS         = 5;
    localparam int TWC_CYCLES     = TWC_MS * 1000000 / LINK_PERIOD_NS;

    // master serial clock: quarter period, from the least low time, rounded up
    localparam int CLK_PERIOD_NS  = 4;
    localparam int T_LOW_NS       = 1300;
    localparam int QTR_CYCLES     = (T_LOW_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

    typedef enum logic [5:0] {
        SL_IDLE = 6'h01,
        SL_CTRL = 6'h02,
        SL_ADDR = 6'h04,
        SL_WR   = 6'h08,
        SL_RD   = 6'h10,
        SL_DROP = 6'h20
    } rtcs_slv_st_t;

    typedef enum logic [3:0] {
        MS_IDLE  = 4'h1,
        MS_START = 4'h2,
        MS_BYTE  = 4'h4,
        MS_STOP  = 4'h8
    } rtcs_mst_st_t;

endpackage : rtcs_pkg

// ===== rtcs_bus_if.sv
// rtcs_bus_if: the open-drain two-wire bus between master and slave.
// assumes both lines are pulled high; each party only pulls low through its enable.
`timescale 1ns/1ps
interface rtcs_bus_if;
    logic scl_o_m;
    logic scl_oe_m;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;

    // wired-and of the pull-downs; the pull-up wins when nobody drives
    assign scl = ~(scl_oe_m & ~scl_o_m);
    assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));

    modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m, input scl, input sda);
    modport dev    (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface : rtcs_bus_if

// ===== rtcs_master.sv
// rtcs_master: byte-level bus master making the serial clock by a divider.
// assumes one command at a time on the cmd port; a read byte is followed by the ack bit given in cmd_nack.
`timescale 1ns/1ps
module rtcs_master
    import rtcs_pkg::*;
#(
    parameter int QTR = QTR_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // bus
    rtcs_bus_if.master      bus,
    // command
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_start,
    input  wire logic       cmd_stop,
    input  wire logic       cmd_read,
    input  wire logic       cmd_nack,
    input  wire logic [7:0] cmd_wdata,
    // response
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            rsp_ack
);
    localparam int QW = $clog2(QTR + 1);

    rtcs_mst_st_t   st_q;
    logic [QW-1:0]  qcnt_q;
    logic [1:0]     ph_q;
    logic [3:0]     bit_q;
    logic [7:0]     sh_q;
    logic [1:0]     sda_sy_q;
    logic           held_q;
    logic           stop_q, read_q, nack_q;
    logic           scl_oe_q, sda_oe_q;
    logic           rdy_q, rv_q, rack_q;
    logic [7:0]     rdat_q;

    wire sda_s   = sda_sy_q[1];
    wire tick    = (qcnt_q == '0);
    wire is_ack  = (bit_q == BIT_ACK);
    // a fresh start waits for a released data line
    wire can_go  = held_q | sda_s; // R4
    wire take    = cmd_valid & rdy_q;
    wire bit_oe  = is_ack ? (read_q & ~nack_q) : (~read_q & ~sh_q[7]);

    assign bus.scl_o_m  = 1'b0;
    assign bus.sda_o_m  = 1'b0;
    assign bus.scl_oe_m = scl_oe_q;
    assign bus.sda_oe_m = sda_oe_q;
    assign cmd_ready    = rdy_q;
    assign rsp_valid    = rv_q;
    assign rsp_data     = rdat_q;
    assign rsp_ack      = rack_q;

    always_ff @(posedge clk) begin
        sda_sy_q <= {sda_sy_q[0], bus.sda};
    end

    always_ff @(posedge clk) begin
        if (srst || st_q == MS_IDLE || tick) begin
            qcnt_q <= QW'(QTR - 1);
        end else begin
            qcnt_q <= qcnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        rv_q <= 1'b0;
        if (srst) begin
            st_q     <= MS_IDLE;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            sh_q     <= 8'h00;
            held_q   <= 1'b0;
            stop_q   <= 1'b0;
            read_q   <= 1'b0;
            nack_q   <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rdy_q    <= 1'b0;
            rack_q   <= 1'b0;
            rdat_q   <= 8'h00;
        end else begin
            case (st_q)
                MS_IDLE: begin
                    rdy_q <= can_go & ~take;
                    if (take) begin
                        stop_q  <= cmd_stop;
                        read_q  <= cmd_read;
                        nack_q  <= cmd_nack;
                        sh_q    <= cmd_wdata;
                        ph_q    <= 2'h0;
                        bit_q   <= 4'h0;
                        st_q    <= cmd_start ? MS_START : MS_BYTE;
                    end
                end
                MS_START: if (tick) begin
                    ph_q <= ph_q + 1'b1;
                    case (ph_q)
                        2'h0: sda_oe_q <= 1'b0;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b1; // R2
                        default: begin
                            scl_oe_q <= 1'b1;
                            st_q     <= MS_BYTE;
                        end
                    endcase
                end
                MS_BYTE: if (tick) begin
                    ph_q <= ph_q + 1'b1;
                    case (ph_q)
                        2'h0: sda_oe_q <= bit_oe; // R1 R12
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: begin
                            if (is_ack) begin
                                rack_q <= ~sda_s; // R7
                            end else begin
                                sh_q <= {sh_q[6:0], sda_s}; // R5
                            end
                        end
                        default: begin
                            scl_oe_q <= 1'b1;
                            if (is_ack) begin // R8
                                rv_q   <= 1'b1;
                                rdat_q <= sh_q;
                                held_q <= ~stop_q;
                                st_q   <= stop_q ? MS_STOP : MS_IDLE;
                            end else begin
                                bit_q <= bit_q + 1'b1;
                            end
                        end
                    endcase
                end
                MS_STOP: if (tick) begin
                    ph_q <= ph_q + 1'b1;
                    case (ph_q)
                        2'h0: sda_oe_q <= 1'b1;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b0; // R3
                        default: begin
                            held_q <= 1'b0;
                            st_q   <= MS_IDLE;
                        end
                    endcase
                end
                default: st_q <= MS_IDLE;
            endcase
        end
    end

endmodule : rtcs_master

// ===== rtcs_slave.sv
// rtcs_slave: two-wire slave front end of the rtc, with eeprom write-cycle timer.
// assumes link_clk is far faster than the serial clock; mem_rdata is valid the cycle after a read mem_req.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - data changes only while clock is low
// R2 - data falling with clock high is start
// R3 - data rising with clock high is stop
// R4 - master starts only on an idle bus
// R5 - one bit per clock, sampled while high
// R6 - master sets byte count; accept any count
// R7 - addressed receiver acknowledges every byte
// R8 - master gives ninth clock for acknowledge
// R9 - no eeprom acknowledge during write cycle
// R10 - sram and clock registers still served
// R11 - acknowledge held low through ninth clock high
// R12 - master ends reads with no acknowledge
// R13 - after read nack, release data line
// R14 - eeprom write cycle lasts at most 5 ms
// R15 - device is slave only
// R16 - acknowledge eeprom or sram control code
// R17 - second byte is word address, msb first
// R18 - eeprom write cycle begins at stop
// R19 - out-of-range sram address is not acknowledged
// R20 - start anywhere aborts, expects control byte
// R21 - stop anywhere idles and releases data
module rtcs_slave
    import rtcs_pkg::*;
#(
    parameter int TWC = TWC_CYCLES
) (
    // link clock and reset
    input  wire logic       link_clk,
    input  wire logic       link_srst,
    // bus
    rtcs_bus_if.dev         bus,
    // memory side
    output logic            mem_req,
    output logic            mem_we,
    output logic            mem_ee,
    output logic [7:0]      mem_addr,
    output logic [7:0]      mem_wdata,
    input  wire logic [7:0] mem_rdata,
    // eeprom write cycle
    output logic            ee_start,
    output logic            ee_busy
);
    localparam int BW = $clog2(TWC + 1);

    rtcs_slv_st_t  st_q;
    logic [2:0]    scl_sy_q, sda_sy_q;
    logic [3:0]    cnt_q;
    logic          in_ack_q;
    logic [7:0]    sh_q;
    logic [7:0]    addr_q;
    logic          ee_sel_q, rd_q;
    logic          sda_oe_q;
    logic          req_q, we_q;
    logic [7:0]    maddr_q, wdat_q;
    logic          ee_pend_q, ee_start_q, ee_busy_q;
    logic [BW-1:0] busy_cnt_q;

    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic ee);
        next_addr = ee ? ((a + 8'h01) & EE_ADDR_MASK) : (a + 8'h01);
    endfunction : next_addr

    // [0] only feeds [1]; [2] is the previous synchronised level
    wire scl_s   = scl_sy_q[1];
    wire scl_p   = scl_sy_q[2];
    wire sda_s   = sda_sy_q[1];
    wire sda_p   = sda_sy_q[2];
    wire start_w = scl_s & scl_p & sda_p & ~sda_s; // R2
    wire stop_w  = scl_s & scl_p & ~sda_p & sda_s; // R3
    wire rise    = scl_s & ~scl_p;
    wire fall    = ~scl_s & scl_p;
    wire full    = (cnt_q == BIT_ACK);
    wire rx_st   = (st_q == SL_CTRL) | (st_q == SL_ADDR) | (st_q == SL_WR);
    wire code_ee = (sh_q[7:1] == EE_CODE);
    wire code_rm = (sh_q[7:1] == RAM_CODE);
    wire ctrl_ok = (code_ee & ~ee_busy_q) | code_rm; // R9 R10 R16
    wire addr_ok = ee_sel_q | (sh_q <= RAM_LAST); // R19
    wire ack_ok  = (st_q == SL_CTRL) ? ctrl_ok :
                   (st_q == SL_ADDR) ? addr_ok : (st_q == SL_WR);
    wire [7:0] addr_nx = next_addr(addr_q, ee_sel_q);

    assign bus.sda_o_s  = 1'b0;
    assign bus.sda_oe_s = sda_oe_q; // R15
    assign mem_req      = req_q;
    assign mem_we       = we_q;
    assign mem_ee       = ee_sel_q;
    assign mem_addr     = maddr_q;
    assign mem_wdata    = wdat_q;
    assign ee_start     = ee_start_q;
    assign ee_busy      = ee_busy_q;

    always_ff @(posedge link_clk) begin
        scl_sy_q <= {scl_sy_q[1:0], bus.scl};
        sda_sy_q <= {sda_sy_q[1:0], bus.sda};
    end

    // internally timed write cycle, begun at the closing stop
    always_ff @(posedge link_clk) begin
        if (link_srst) begin
            busy_cnt_q <= '0;
            ee_busy_q  <= 1'b0;
        end else if (ee_start_q) begin
            busy_cnt_q <= BW'(TWC); // R14
            ee_busy_q  <= 1'b1;
        end else if (busy_cnt_q != '0) begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
            ee_busy_q  <= (busy_cnt_q != BW'(1));
        end
    end

    always_ff @(posedge link_clk) begin
        req_q      <= 1'b0;
        ee_start_q <= 1'b0;
        if (link_srst) begin
            st_q      <= SL_IDLE;
            cnt_q     <= 4'h0;
            in_ack_q  <= 1'b0;
            sh_q      <= 8'h00;
            addr_q    <= 8'h00;
            ee_sel_q  <= 1'b0;
            rd_q      <= 1'b0;
            sda_oe_q  <= 1'b0;
            we_q      <= 1'b0;
            maddr_q   <= 8'h00;
            wdat_q    <= 8'h00;
            ee_pend_q <= 1'b0;
        end else if (start_w) begin
            // covers a repeated start in mid-byte as well
            st_q     <= SL_CTRL; // R20
            cnt_q    <= 4'h0;
            in_ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_w) begin
            st_q       <= SL_IDLE; // R21
            in_ack_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
            ee_pend_q  <= 1'b0;
            ee_start_q <= ee_pend_q; // R18
        end else if (rx_st) begin
            if (rise && !full && !in_ack_q) begin
                sh_q  <= {sh_q[6:0], sda_s}; // R5 R17
                cnt_q <= cnt_q + 1'b1;
            end else if (fall && full && !in_ack_q) begin
                in_ack_q <= 1'b1;
                sda_oe_q <= ack_ok; // R7 R11
                case (st_q)
                    SL_CTRL: begin
                        ee_sel_q <= code_ee;
                        rd_q     <= sh_q[0];
                        if (ctrl_ok && sh_q[0]) begin
                            req_q   <= 1'b1;
                            we_q    <= 1'b0;
                            maddr_q <= addr_q;
                        end
                    end
                    SL_ADDR: if (addr_ok) begin
                        addr_q <= ee_sel_q ? (sh_q & EE_ADDR_MASK) : sh_q;
                    end
                    default: begin // R6
                        req_q     <= 1'b1;
                        we_q      <= 1'b1;
                        maddr_q   <= addr_q;
                        wdat_q    <= sh_q;
                        addr_q    <= addr_nx;
                        ee_pend_q <= ee_pend_q | ee_sel_q;
                    end
                endcase
            end else if (fall && in_ack_q) begin
                // ack released on the falling clock, so it stood through the whole high phase
                in_ack_q <= 1'b0;
                cnt_q    <= 4'h0;
                sda_oe_q <= 1'b0;
                if (!sda_oe_q) begin
                    st_q <= SL_DROP;
                end else if (st_q == SL_CTRL && rd_q) begin
                    st_q     <= SL_RD;
                    sh_q     <= mem_rdata;
                    sda_oe_q <= ~mem_rdata[7]; // R1
                end else begin
                    st_q <= (st_q == SL_CTRL) ? SL_ADDR : SL_WR;
                end
            end
        end else if (st_q == SL_RD) begin
            if (rise && !full && !in_ack_q) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (fall && !full && !in_ack_q) begin
                sda_oe_q <= ~sh_q[6]; // R1
                sh_q     <= {sh_q[6:0], 1'b0};
            end else if (fall && full && !in_ack_q) begin
                sda_oe_q <= 1'b0;
                in_ack_q <= 1'b1;
                addr_q   <= addr_nx;
            end else if (rise && in_ack_q) begin
                if (sda_s) begin
                    st_q <= SL_DROP; // R13
                end else begin
                    req_q   <= 1'b1;
                    we_q    <= 1'b0;
                    maddr_q <= addr_q;
                end
            end else if (fall && in_ack_q) begin
                in_ack_q <= 1'b0;
                cnt_q    <= 4'h0;
                sh_q     <= mem_rdata;
                sda_oe_q <= ~mem_rdata[7];
            end
        end
    end

endmodule : rtcs_slave

// ===== rtcs_checker.sv
// rtcs_checker: bus-level properties of the two-wire link between master and slave.
// assumes it watches the interface that joins the two design ends; clk and link_clk are unrelated.
`timescale 1ns/1ps
module rtcs_checker (
    // system clock domain
    input wire logic clk,
    input wire logic srst,
    // link clock domain
    input wire logic link_clk,
    input wire logic link_srst,
    // bus
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_s
);
    // slave side, sampled on its own clock
    AST_SLV_CHANGE_SCL_LOW: assert property (@(posedge link_clk) disable iff (link_srst)
        $changed(sda_oe_s) |-> !scl) else $error("slave moved sda while scl high");
    AST_SLV_STABLE_HIGH: assert property (@(posedge link_clk) disable iff (link_srst)
        scl && $past(scl) |-> $stable(sda_oe_s)) else $error("slave data not stable in scl high");
    AST_ACK_HELD: assert property (@(posedge link_clk) disable iff (link_srst)
        $rose(scl) && sda_oe_s |-> sda_oe_s [*8]) else $error("slave low not held through scl high");
    AST_STOP_RELEASE: assert property (@(posedge link_clk) disable iff (link_srst)
        scl && $past(scl) && $rose(sda) |=> !sda_oe_s [*8]) else $error("slave drove sda after stop");
    // master side: only it frames the bus
    AST_START_BY_MASTER: assert property (@(posedge clk) disable iff (srst)
        $fell(sda) && scl |-> sda_oe_m && !sda_oe_s) else $error("start not made by master");
    AST_START_IDLE: assert property (@(posedge clk) disable iff (srst)
        $rose(sda_oe_m) && scl |-> $past(sda) && $past(scl) && !sda_oe_s) else $error("start on a busy bus");
    AST_START_HOLD: assert property (@(posedge clk) disable iff (srst)
        $rose(sda_oe_m) && scl |-> scl [*6]) else $error("scl fell too soon after start");
    AST_STOP_HOLD: assert property (@(posedge clk) disable iff (srst)
        $fell(sda_oe_m) && scl |-> scl [*6]) else $error("scl fell too soon after stop");
    AST_SCL_HIGH: assert property (@(posedge clk) disable iff (srst)
        $fell(scl_oe_m) |-> ##[0:3] scl ##1 scl [*7]) else $error("scl high phase too short");
    AST_SCL_LOW: assert property (@(posedge clk) disable iff (srst)
        $fell(scl) |-> !scl [*8]) else $error("scl low phase too short");

    COV_ACK: cover property (@(posedge link_clk) disable iff (link_srst) $rose(sda_oe_s));
    COV_START: cover property (@(posedge clk) disable iff (srst) $fell(sda) && scl);
    COV_STOP: cover property (@(posedge clk) disable iff (srst) $rose(sda) && scl);
endmodule : rtcs_checker

// ===== rtc_i2c_slave_interface_tb.sv
// rtc_i2c_slave_interface_tb: master and slave joined by the bus interface, driven from the command port.
// assumes short quarter and write-cycle parameters; a behavioural memory answers the slave's mem port.
`timescale 1ns/1ps
module rtc_i2c_slave_interface_tb;
    import rtcs_pkg::*;

    localparam int TWC_TB = 2000;
    localparam logic [7:0] RAM_W = {RAM_CODE, 1'b0};
    localparam logic [7:0] RAM_R = {RAM_CODE, 1'b1};
    localparam logic [7:0] EE_W  = {EE_CODE, 1'b0};

    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       srst = 1'b1;
    logic       link_srst = 1'b1;
    logic       cmd_valid = 1'b0;
    logic       cmd_ready;
    logic       cmd_start = 1'b0;
    logic       cmd_stop = 1'b0;
    logic       cmd_read = 1'b0;
    logic       cmd_nack = 1'b0;
    logic [7:0] cmd_wdata = 8'h00;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_ack;
    logic       mem_req;
    logic       mem_we;
    logic       mem_ee;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata = 8'h00;
    logic       ee_start;
    logic       ee_busy;
    logic [7:0] mem [0:511];
    int         busy_cnt = 0;
    int         start_cnt = 0;
    int         failures = 0;
    int         check_count = 0;

    always #2 clk = ~clk;
    // odd offset keeps the link clock out of phase with clk
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    rtcs_bus_if bus_if_inst ();

    rtcs_master #(.QTR(8)) rtcs_master_inst (
        .clk(clk), .srst(srst), .bus(bus_if_inst.master),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
        .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack)
    );

    rtcs_slave #(.TWC(TWC_TB)) rtcs_slave_inst (
        .link_clk(link_clk), .link_srst(link_srst), .bus(bus_if_inst.dev),
        .mem_req(mem_req), .mem_we(mem_we), .mem_ee(mem_ee), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ee_start(ee_start), .ee_busy(ee_busy)
    );

    rtcs_checker rtcs_checker_inst (
        .clk(clk), .srst(srst), .link_clk(link_clk), .link_srst(link_srst),
        .scl(bus_if_inst.scl), .sda(bus_if_inst.sda), .scl_oe_m(bus_if_inst.scl_oe_m),
        .sda_oe_m(bus_if_inst.sda_oe_m), .sda_oe_s(bus_if_inst.sda_oe_s)
    );

    // eeprom and sram share one array, split by the target bit
    always @(posedge link_clk) begin
        if (mem_req === 1'b1) begin
            if (mem_we === 1'b1) begin
                mem[{mem_ee, mem_addr}] <= mem_wdata;
            end
            mem_rdata <= mem[{mem_ee, mem_addr}];
        end
        if (ee_busy === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end
        if (ee_start === 1'b1) begin
            start_cnt <= start_cnt + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one byte plus its ack bit; waits are bounded so a hang shows as a mismatch
    task automatic xfer(input logic st, input logic sp, input logic rd, input logic nk,
                        input logic [7:0] wd, input logic ea, input logic [7:0] ed);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_start = st;
        cmd_stop  = sp;
        cmd_read  = rd;
        cmd_nack  = nk;
        cmd_wdata = wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 5000);
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check({15'h0, rsp_valid}, 16'h0001);
        check({15'h0, rsp_ack}, {15'h0, ea});
        check({8'h0, rsp_data}, {8'h0, ed});
    endtask : xfer

    task automatic t_ram_write;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, RAM_W, 1'b1, RAM_W);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h20, 1'b1, 8'h20);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'hA5, 1'b1, 8'hA5);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h3C, 1'b1, 8'h3C);
        repeat (40) @(negedge clk);
        check({8'h0, mem[{1'b0, 8'h20}]}, 16'h00A5);
        check({8'h0, mem[{1'b0, 8'h21}]}, 16'h003C);
        $display("done sram write");
    endtask : t_ram_write

    task automatic t_ram_read;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, RAM_W, 1'b1, RAM_W);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h20, 1'b1, 8'h20);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, RAM_R, 1'b1, RAM_R);
        xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'hFF, 1'b1, 8'hA5);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'hFF, 1'b0, 8'h3C);
        repeat (40) @(negedge clk);
        check({15'h0, bus_if_inst.sda}, 16'h0001);
        $display("done sram read");
    endtask : t_ram_read

    task automatic t_refuse;
        xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'hA0, 1'b0, 8'hA0);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, RAM_W, 1'b1, RAM_W);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h60, 1'b0, 8'h60);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, RAM_W, 1'b1, RAM_W);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, RAM_LAST, 1'b1, RAM_LAST);
        $display("done refusals");
    endtask : t_refuse

    task automatic t_eeprom;
        int n;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, EE_W, 1'b1, EE_W);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 1'b1, 8'h05);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h77, 1'b1, 8'h77);
        repeat (100) @(negedge clk);
        check(start_cnt[15:0], 16'h0001);
        check({15'h0, ee_busy}, 16'h0001);
        xfer(1'b1, 1'b1, 1'b0, 1'b0, EE_W, 1'b0, EE_W);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, RAM_W, 1'b1, RAM_W);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h21, 1'b1, 8'h21);
        check({15'h0, ee_busy}, 16'h0001);
        n = 0;
        while (ee_busy !== 1'b0 && n < 10000) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        check(busy_cnt[15:0], TWC_TB[15:0]);
        check({8'h0, mem[{1'b1, 8'h05}]}, 16'h0077);
        xfer(1'b1, 1'b1, 1'b0, 1'b0, EE_W, 1'b1, EE_W);
        $display("done eeprom write cycle");
    endtask : t_eeprom

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // about twenty bytes of 1.2 us each plus one write cycle
    initial begin
        #300000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge link_clk);
        link_srst = 1'b0;
        repeat (10) @(negedge clk);
        t_ram_write();
        t_ram_read();
        t_refuse();
        t_eeprom();
        finish_test();
    end
endmodule : rtc_i2c_slave_interface_tb
